// ### src/trouble_code_pkg.sv
// Constants shared by the trouble code blink reporter.
`default_nettype none
package trouble_code_pkg;
    // ========================================
    // Store geometry
    localparam int          STORE_DEPTH    = 6;
    localparam int          IDX_W          = 3;
    localparam int          CODE_W         = 7;
    localparam int          DIGIT_W        = 4;
    localparam logic [1:0]  REPEAT_COUNT   = 2'h3;
    // ========================================
    // Fault sources and their codes, listed in code order
    localparam int          NUM_FAULTS     = 22;
    localparam int          FAULT_IDX_W    = 5;
    localparam logic [CODE_W-1:0] CODE_THROTTLE_LOW  = 7'h0C;
    localparam logic [CODE_W-1:0] CODE_MANIFOLD_LOW  = 7'h0E;
    localparam logic [CODE_W-1:0] CODE_THROTTLE_HIGH = 7'h16;
    localparam logic [CODE_W-1:0] CODE_MANIFOLD_HIGH = 7'h18;
    localparam logic [CODE_W-1:0] CODE_CRANK_PULSES  = 7'h34;
    localparam logic [CODE_W-1:0] CODE_CAM_PATTERN   = 7'h35;
    localparam logic [CODE_W-1:0] CODE_WATCHDOG      = 7'h38;
    // ========================================
    // Timing: one lamp unit is 0.4 s
    localparam int          CLK_HZ         = 100_000_000;
    localparam int          UNIT_MS        = 400;
    localparam int          UNIT_CYCLES    = CLK_HZ / 1000 * UNIT_MS;
    localparam int          TICK_W         = 26;
    localparam int          SELFTEST_MS    = 2400;
    localparam logic [3:0]  SELFTEST_UNITS = 4'(SELFTEST_MS / UNIT_MS);
    localparam logic [3:0]  FLASH_ON_UNITS = 4'h1;
    localparam logic [3:0]  FLASH_OFF_UNITS = 4'h1;
    localparam int          DIGIT_GAP_MS   = 1200;
    localparam int          CODE_GAP_MS    = 2400;
    // Gaps include the dark unit that already follows the last flash.
    localparam logic [3:0]  DIGIT_GAP_UNITS = 4'(DIGIT_GAP_MS / UNIT_MS - 1);
    localparam logic [3:0]  CODE_GAP_UNITS  = 4'(CODE_GAP_MS / UNIT_MS - 1);
    // ========================================
    // Reporter states
    typedef enum logic [2:0] {
        ST_SELFTEST,
        ST_IDLE,
        ST_FLASH_ON,
        ST_FLASH_OFF,
        ST_DIGIT_GAP,
        ST_CODE_GAP
    } rep_state_e;
endpackage : trouble_code_pkg
`default_nettype wire

// ### src/trouble_code_blink_reporter.sv
// Trouble code store, fault lamp driver and blink-code reporter.
`timescale 1ns/1ps
`default_nettype none
module trouble_code_blink_reporter #(
    // Clock cycles per lamp unit; the default makes a unit 0.4 s at 100 MHz.
    parameter int UNIT_LEN = trouble_code_pkg::UNIT_CYCLES
) (
    input  wire logic                             i_mclk,
    input  wire logic                             i_rst,
    input  wire logic                             i_ce,
    input  wire logic                             i_key_on,
    input  wire logic                             i_test_button,
    input  wire logic                             i_engine_running,
    input  wire logic                             i_throttle_low,
    input  wire logic                             i_throttle_high,
    input  wire logic                             i_manifold_low,
    input  wire logic                             i_manifold_high,
    input  wire logic                             i_crank_pulse_error,
    input  wire logic                             i_watchdog_fail,
    input  wire logic                             i_cam_bad_pattern,
    input  wire logic                             i_cam_lost,
    input  wire logic                             i_crank_ref_pulse,
    input  wire logic                             i_inject_pulse,
    output logic                                  o_fault_lamp,
    output logic [trouble_code_pkg::IDX_W-1:0]    o_code_count,
    output logic                                  o_calc_injection_mode,
    output logic [1:0]                            o_inject_phase,
    output logic [15:0]                           o_crank_period
);
    import trouble_code_pkg::*;

    // ========================================
    // Helpers
    function automatic logic [DIGIT_W-1:0] tens_of(input logic [CODE_W-1:0] c);
        tens_of = DIGIT_W'(c / 7'h0A);
    endfunction : tens_of

    function automatic logic [DIGIT_W-1:0] units_of(input logic [CODE_W-1:0] c);
        units_of = DIGIT_W'(c % 7'h0A);
    endfunction : units_of

    // ========================================
    // Fault capture and code store
    logic [CODE_W-1:0] store_q [STORE_DEPTH];
    logic [CODE_W-1:0] store_d [STORE_DEPTH];
    logic [IDX_W-1:0]  count_q, count_d;
    logic              key_q, key_d;

    logic [CODE_W-1:0] fault_codes [7];
    logic [6:0]        fault_hit;

    always_comb begin
        fault_codes[0] = CODE_THROTTLE_LOW;
        fault_codes[1] = CODE_THROTTLE_HIGH;
        fault_codes[2] = CODE_MANIFOLD_LOW;
        fault_codes[3] = CODE_MANIFOLD_HIGH;
        fault_codes[4] = CODE_CRANK_PULSES;
        fault_codes[5] = CODE_WATCHDOG;
        fault_codes[6] = CODE_CAM_PATTERN;
        fault_hit = {i_cam_bad_pattern & i_engine_running, i_watchdog_fail,
                     i_crank_pulse_error, i_manifold_high, i_manifold_low,
                     i_throttle_high, i_throttle_low};
    end

    // Several faults in one cycle are all taken, lowest source first, while the store has room.
    always_comb begin
        logic dup;
        dup = 1'b0;
        store_d = store_q;
        count_d = count_q;
        key_d   = i_key_on;
        for (int f = 0; f < 7; f++) begin
            if (fault_hit[f]) begin
                dup = 1'b0;
                for (int s = 0; s < STORE_DEPTH; s++) begin
                    if (IDX_W'(s) < count_d && store_d[s] == fault_codes[f]) begin
                        dup = 1'b1;
                    end
                end
                if (!dup && count_d < IDX_W'(STORE_DEPTH)) begin
                    store_d[count_d] = fault_codes[f];
                    count_d = count_d + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            for (int s = 0; s < STORE_DEPTH; s++) begin
                store_q[s] <= '0;
            end
            count_q <= '0;
            key_q   <= 1'b0;
        end else if (i_ce) begin
            store_q <= store_d;
            count_q <= count_d;
            key_q   <= key_d;
        end
    end

    // ========================================
    // Unit tick
    logic [TICK_W-1:0] tick_q, tick_d;
    logic              unit_tick;
    logic              restart;

    always_comb begin
        unit_tick = (tick_q == TICK_W'(UNIT_LEN - 1));
        // A new self-test or readout restarts the unit, so its first unit is full length.
        tick_d    = (unit_tick || restart) ? '0 : tick_q + 1'b1;
    end

    // ========================================
    // Lamp reporter
    rep_state_e        state_q, state_d;
    logic [3:0]        units_q, units_d;
    logic [DIGIT_W-1:0] flash_q, flash_d;
    logic              digit_q, digit_d;
    logic [1:0]        rep_q, rep_d;
    logic [IDX_W-1:0]  idx_q, idx_d;
    logic              lamp_q, lamp_d;
    logic [DIGIT_W-1:0] cur_digit;

    always_comb begin
        state_d = state_q;
        units_d = units_q;
        flash_d = flash_q;
        digit_d = digit_q;
        rep_d   = rep_q;
        idx_d   = idx_q;
        restart = 1'b0;
        cur_digit = digit_q ? units_of(store_q[idx_q]) : tens_of(store_q[idx_q]);
        if (i_key_on && !key_q) begin
            state_d = ST_SELFTEST;
            units_d = SELFTEST_UNITS;
            restart = 1'b1;
        end else begin
            case (state_q)
                ST_SELFTEST: begin
                    if (unit_tick) begin
                        units_d = units_q - 1'b1;
                        if (units_q == 4'h1) begin
                            state_d = ST_IDLE;
                        end
                    end
                end
                ST_IDLE: begin
                    if (i_test_button && count_q != '0) begin
                        state_d = ST_FLASH_ON;
                        units_d = FLASH_ON_UNITS;
                        flash_d = 4'h1;
                        digit_d = 1'b0;
                        rep_d   = 2'h1;
                        idx_d   = '0;
                        restart = 1'b1;
                    end
                end
                ST_FLASH_ON: begin
                    if (unit_tick && units_q == 4'h1) begin
                        state_d = ST_FLASH_OFF;
                        units_d = FLASH_OFF_UNITS;
                    end else if (unit_tick) begin
                        units_d = units_q - 1'b1;
                    end
                end
                ST_FLASH_OFF: begin
                    if (unit_tick && units_q == 4'h1) begin
                        if (flash_q < cur_digit) begin
                            state_d = ST_FLASH_ON;
                            units_d = FLASH_ON_UNITS;
                            flash_d = flash_q + 1'b1;
                        end else if (!digit_q) begin
                            state_d = ST_DIGIT_GAP;
                            units_d = DIGIT_GAP_UNITS;
                        end else begin
                            state_d = ST_CODE_GAP;
                            units_d = CODE_GAP_UNITS;
                        end
                    end else if (unit_tick) begin
                        units_d = units_q - 1'b1;
                    end
                end
                ST_DIGIT_GAP, ST_CODE_GAP: begin
                    if (unit_tick && units_q == 4'h1) begin
                        state_d = ST_FLASH_ON;
                        units_d = FLASH_ON_UNITS;
                        flash_d = 4'h1;
                        digit_d = (state_q == ST_DIGIT_GAP);
                        if (state_q == ST_CODE_GAP) begin
                            if (rep_q == REPEAT_COUNT) begin
                                rep_d = 2'h1;
                                idx_d = (idx_q + 1'b1 >= count_q) ? '0 : idx_q + 1'b1;
                            end else begin
                                rep_d = rep_q + 1'b1;
                            end
                        end
                    end else if (unit_tick) begin
                        units_d = units_q - 1'b1;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
            if (state_q != ST_SELFTEST && state_q != ST_IDLE && !i_test_button) begin
                state_d = ST_IDLE;
            end
        end
        case (state_d)
            ST_SELFTEST: lamp_d = 1'b1;
            ST_IDLE:     lamp_d = (count_d != '0) && key_d;
            ST_FLASH_ON: lamp_d = 1'b1;
            default:     lamp_d = 1'b0;
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            units_q <= '0;
            flash_q <= '0;
            digit_q <= 1'b0;
            rep_q   <= 2'h1;
            idx_q   <= '0;
            lamp_q  <= 1'b0;
            tick_q  <= '0;
        end else if (i_ce) begin
            state_q <= state_d;
            units_q <= units_d;
            flash_q <= flash_d;
            digit_q <= digit_d;
            rep_q   <= rep_d;
            idx_q   <= idx_d;
            lamp_q  <= lamp_d;
            tick_q  <= tick_d;
        end
    end

    // ========================================
    // Crank reference and injection sequencing
    // The injection phase advances on each injection pulse; it is never
    // reset by a cam fault, so a restart keeps the established order.
    logic [15:0] crank_cnt_q, crank_cnt_d;
    logic [15:0] period_q, period_d;
    logic [1:0]  phase_q, phase_d;
    logic        calc_q, calc_d;

    always_comb begin
        crank_cnt_d = (crank_cnt_q == 16'hFFFF) ? crank_cnt_q : crank_cnt_q + 1'b1;
        period_d    = period_q;
        if (i_crank_ref_pulse) begin
            period_d    = crank_cnt_q;
            crank_cnt_d = '0;
        end
        calc_d = calc_q;
        if (i_cam_lost && i_engine_running) begin
            calc_d = 1'b1;
        end else if (!i_cam_lost) begin
            calc_d = 1'b0;
        end
        phase_d = i_inject_pulse ? phase_q + 1'b1 : phase_q;
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            crank_cnt_q <= '0;
            period_q    <= '0;
            phase_q     <= '0;
            calc_q      <= 1'b0;
        end else if (i_ce) begin
            crank_cnt_q <= crank_cnt_d;
            period_q    <= period_d;
            phase_q     <= phase_d;
            calc_q      <= calc_d;
        end
    end

    always_comb begin
        o_fault_lamp          = lamp_q;
        o_code_count          = count_q;
        o_calc_injection_mode = calc_q;
        o_inject_phase        = phase_q;
        o_crank_period        = period_q;
    end
endmodule : trouble_code_blink_reporter
`default_nettype wire

// ### sim/trouble_code_chk.sv
// Assertion checker bound to the ports of the trouble code blink reporter.
`timescale 1ns/1ps
`default_nettype none
module trouble_code_chk
    import trouble_code_pkg::*;
(
    input wire logic              i_mclk,
    input wire logic              i_rst,
    input wire logic              i_ce,
    input wire logic              i_key_on,
    input wire logic              i_engine_running,
    input wire logic              i_throttle_low,
    input wire logic              i_throttle_high,
    input wire logic              i_manifold_low,
    input wire logic              i_manifold_high,
    input wire logic              i_crank_pulse_error,
    input wire logic              i_watchdog_fail,
    input wire logic              i_cam_bad_pattern,
    input wire logic              i_cam_lost,
    input wire logic              i_crank_ref_pulse,
    input wire logic              i_inject_pulse,
    input wire logic              o_fault_lamp,
    input wire logic [IDX_W-1:0]  o_code_count,
    input wire logic              o_calc_injection_mode,
    input wire logic [1:0]        o_inject_phase,
    input wire logic [15:0]       o_crank_period
);
    // ========================================
    // Properties
    wire logic any_fault = i_throttle_low | i_throttle_high | i_manifold_low | i_manifold_high
                         | i_crank_pulse_error | i_watchdog_fail | i_cam_bad_pattern;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    a_count_max: assert property (o_code_count <= 3'(STORE_DEPTH))
        else $error("code count above store depth");
    a_count_keep: assert property (o_code_count >= $past(o_code_count))
        else $error("code count dropped without reset");
    a_store_fault: assert property (i_ce && i_throttle_low && o_code_count == 3'h0
        |=> o_code_count != 3'h0) else $error("fault not stored");
    a_no_fault_hold: assert property (i_ce && !any_fault |=> $stable(o_code_count))
        else $error("count changed with no fault");
    a_freeze_hold: assert property (!i_ce |=> $stable(o_code_count) && $stable(o_fault_lamp)
        && $stable(o_inject_phase)) else $error("state moved with enable low");
    a_selftest_lamp: assert property (i_ce && $past(i_ce) && i_key_on && !$past(i_key_on)
        |=> o_fault_lamp [*8]) else $error("lamp not lit after key on");
    a_calc_set: assert property (i_ce && i_cam_lost && i_engine_running
        |=> o_calc_injection_mode) else $error("calculated mode not entered");
    a_calc_clear: assert property (i_ce && !i_cam_lost |=> !o_calc_injection_mode)
        else $error("calculated mode without cam loss");
    a_phase_step: assert property (i_ce && i_inject_pulse
        |=> o_inject_phase == $past(o_inject_phase) + 2'h1) else $error("phase did not step");
    a_crank_hold: assert property (i_ce && !i_crank_ref_pulse |=> $stable(o_crank_period))
        else $error("crank period moved without reference");
    c_store_full: cover property (o_code_count == 3'(STORE_DEPTH));
    c_calc_mode: cover property (o_calc_injection_mode);
    c_key_on: cover property (i_key_on && !$past(i_key_on));
endmodule : trouble_code_chk
bind trouble_code_blink_reporter trouble_code_chk i_trouble_code_chk (.i_mclk, .i_rst, .i_ce,
    .i_key_on, .i_engine_running, .i_throttle_low, .i_throttle_high, .i_manifold_low,
    .i_manifold_high, .i_crank_pulse_error, .i_watchdog_fail, .i_cam_bad_pattern, .i_cam_lost,
    .i_crank_ref_pulse, .i_inject_pulse, .o_fault_lamp, .o_code_count, .o_calc_injection_mode,
    .o_inject_phase, .o_crank_period);
`default_nettype wire

// ### sim/test_panel.sv
// Operator panel model: test push button and a watcher of the fault lamp.
`timescale 1ns/1ps
`default_nettype none
module test_panel (
    input  wire logic i_mclk,
    input  wire logic i_hold,
    input  wire logic i_lamp,
    output logic      o_button,
    output var int    o_lamp_rises
);
    logic lamp_q = 1'b0;
    initial o_lamp_rises = 0;
    // The operator keeps the button held for as long as readout is wanted.
    assign o_button = i_hold;
    always @(posedge i_mclk) begin
        if (i_lamp && !lamp_q) o_lamp_rises <= o_lamp_rises + 1;
        lamp_q <= i_lamp;
    end
endmodule : test_panel
`default_nettype wire

// ### sim/trouble_code_blink_reporter_tb.sv
// Self-checking testbench for the trouble code blink reporter.
`timescale 1ns/1ps
`default_nettype none
module trouble_code_blink_reporter_tb;
    import trouble_code_pkg::*;
    // A short lamp unit brings every blink interval within reach of the run.
    localparam int    U = 8;
    logic             mclk = 1'b0, rst = 1'b1, ce = 1'b1, key = 1'b0, run = 1'b0;
    logic             hold = 1'b0, lost = 1'b0, ref_p = 1'b0, inj = 1'b0;
    logic             button, lamp, calc;
    logic [6:0]       flt = 7'h00;
    logic [IDX_W-1:0] cnt;
    logic [1:0]       phase;
    logic [15:0]      period, p1;
    int               num_errors = 0, total_checks = 0, cycles = 0, rises, r0;
    trouble_code_blink_reporter #(.UNIT_LEN(U)) i_trouble_code_blink_reporter (.i_mclk(mclk),
        .i_rst(rst), .i_ce(ce), .i_key_on(key), .i_test_button(button), .i_engine_running(run),
        .i_throttle_low(flt[0]), .i_throttle_high(flt[1]), .i_manifold_low(flt[2]),
        .i_manifold_high(flt[3]), .i_crank_pulse_error(flt[4]), .i_watchdog_fail(flt[5]),
        .i_cam_bad_pattern(flt[6]), .i_cam_lost(lost), .i_crank_ref_pulse(ref_p),
        .i_inject_pulse(inj), .o_fault_lamp(lamp), .o_code_count(cnt),
        .o_calc_injection_mode(calc), .o_inject_phase(phase), .o_crank_period(period));
    test_panel i_test_panel (.i_mclk(mclk), .i_hold(hold), .i_lamp(lamp), .o_button(button),
        .o_lamp_rises(rises));
    initial forever #5 mclk = ~mclk;
    // ========================================
    // Shared tasks
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic do_reset();
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(1);
    endtask : do_reset
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    // Counts the cycles for which the lamp stays at one level, capped so a stuck lamp ends.
    task automatic run_len(input logic lvl, output int n);
        n = 0;
        while (lamp === lvl && n < 1000) begin
            tick(1);
            n++;
        end
    endtask : run_len
    task automatic read_digit(output int flashes, output int dark);
        int lit;
        flashes = 0;
        dark = 0;
        while (dark <= U && flashes < 10) begin
            run_len(1'b1, lit);
            check("flash lit", 16'(lit), 16'(U));
            run_len(1'b0, dark);
            if (dark <= U) check("flash dark", 16'(dark), 16'(U));
            flashes++;
        end
    endtask : read_digit
    task automatic expect_code(input int code);
        int n, d;
        read_digit(n, d);
        check("tens flashes", 16'(n), 16'(code / 10));
        check("digit gap", 16'(d), 16'(DIGIT_GAP_MS / UNIT_MS * U));
        read_digit(n, d);
        check("units flashes", 16'(n), 16'(code % 10));
        check("code gap", 16'(d), 16'(CODE_GAP_MS / UNIT_MS * U));
    endtask : expect_code
    // ========================================
    // Scenarios
    task automatic test_store();
        int order[8] = '{0, 0, 1, 2, 3, 4, 5, 6};
        ce = 1'b0;
        flt = 7'h01;
        tick(3);
        check("frozen count", 16'(cnt), 16'h0000);
        flt = 7'h00;
        ce = 1'b1;
        run = 1'b1;
        for (int i = 0; i < 8; i++) begin
            flt = 7'h01 << order[i];
            tick(1);
            check("count", 16'(cnt), 16'((i == 0) ? 1 : ((i > 6) ? 6 : i)));
        end
        flt = 7'h00;
        tick(200);
        check("count kept", 16'(cnt), 16'(STORE_DEPTH));
        do_reset();
        check("count cleared", 16'(cnt), 16'h0000);
        $display("test_store done");
    endtask : test_store
    task automatic test_selftest();
        int n;
        key = 1'b1;
        tick(1);
        run_len(1'b1, n);
        check("self-test time", 16'(n >= 5 * U && n <= 15 * U / 2), 16'h0001);
        check("lamp after self-test", 16'(lamp), 16'h0000);
        flt = 7'h01;
        tick(1);
        flt = 7'h00;
        check("fault lamp", 16'(lamp), 16'h0001);
        tick(3 * U);
        check("steady lamp", 16'(lamp), 16'h0001);
        key = 1'b0;
        tick(1);
        check("key off lamp", 16'(lamp), 16'h0000);
        key = 1'b1;
        tick(8 * U);
        check("lamp after second self-test", 16'(lamp), 16'h0001);
        key = 1'b0;
        tick(1);
        $display("test_selftest done");
    endtask : test_selftest
    task automatic test_readout();
        do_reset();
        // Stored against source order, so the report must follow arrival order.
        flt = 7'h20;
        tick(1);
        flt = 7'h08;
        tick(1);
        flt = 7'h01;
        tick(1);
        flt = 7'h00;
        check("three stored", 16'(cnt), 16'h0003);
        hold = 1'b1;
        tick(1);
        for (int r = 0; r < 3; r++) begin
            expect_code(56);
        end
        for (int r = 0; r < 3; r++) begin
            expect_code(24);
        end
        for (int r = 0; r < 3; r++) begin
            expect_code(12);
        end
        expect_code(56);
        hold = 1'b0;
        tick(2);
        r0 = rises;
        tick(4 * U);
        check("lamp after release", 16'(lamp), 16'h0000);
        check("flashes after release", 16'(rises - r0), 16'h0000);
        $display("test_readout done");
    endtask : test_readout
    task automatic crank(input int gap);
        ref_p = 1'b1;
        tick(1);
        ref_p = 1'b0;
        tick(gap - 1);
    endtask : crank
    task automatic test_engine();
        logic [1:0] p0;
        lost = 1'b1;
        tick(2);
        check("calc mode", 16'(calc), 16'h0001);
        p0 = phase;
        repeat (5) begin
            inj = 1'b1;
            tick(1);
            inj = 1'b0;
            tick(1);
        end
        check("phase", 16'(phase), 16'(2'(p0 + 2'h1 + 2'h0 + 2'h0 + 2'h0 + 2'h0)));
        lost = 1'b0;
        run = 1'b0;
        tick(2);
        check("calc off", 16'(calc), 16'h0000);
        lost = 1'b1;
        tick(2);
        check("calc not running", 16'(calc), 16'h0000);
        lost = 1'b0;
        crank(40);
        crank(80);
        p1 = period;
        crank(1);
        check("period step", period - p1, 16'h0028);
        $display("test_engine done");
    endtask : test_engine
    // A run far beyond the few thousand cycles needed means a hang.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        tick(10);
        rst = 1'b0;
        tick(1);
        check("reset count", 16'(cnt), 16'h0000);
        test_store();
        test_selftest();
        test_readout();
        test_engine();
        conclude();
    end
endmodule : trouble_code_blink_reporter_tb
`default_nettype wire
